// ==== design/dmb_defines.svh ====
// constants shared by the dual port mailbox bypass block
`ifndef DMB_DEFINES_SVH
`define DMB_DEFINES_SVH

`define DMB_WORD_W      36
`define DMB_WORD_ZERO   36'h0
`define DMB_FULL_N_RST  1'h1
`define DMB_BIT_RST     1'h0
`define DMB_DIR_A_WRITE 1'h1
`define DMB_DIR_B_WRITE 1'h0
`define DMB_FULL_N_MAIL 1'h0
`define DMB_CTL_IDLE    5'h08

`endif

// ==== design/dmb_pkg.sv ====
// types of the dual port mailbox bypass block
`include "dmb_defines.svh"

package dmb_pkg;

  typedef logic [`DMB_WORD_W-1:0] dmb_word_t;

  // control pins of one port, all sampled together
  typedef struct packed {
    logic port_clock;
    logic select_n;
    logic gate;
    logic direction;
    logic mail_select;
  } dmb_port_ctl_t;

endpackage

// ==== design/dmb_port_sync.sv ====
// two-stage synchroniser and clock edge detector for one port
`include "dmb_defines.svh"

module dmb_port_sync (
  input  wire logic                   i_sys_clk,
  input  wire logic                   i_sys_rst,
  input  wire dmb_pkg::dmb_port_ctl_t i_ctl,
  input  wire dmb_pkg::dmb_word_t     i_bus,
  output logic                        o_rise,
  output dmb_pkg::dmb_port_ctl_t      o_ctl,
  output dmb_pkg::dmb_word_t          o_bus
);

  ////////////////////////////////////////////////////////////////////////////
  // stage one feeds stage two only
  dmb_pkg::dmb_port_ctl_t ctl_s1_ff;
  dmb_pkg::dmb_port_ctl_t ctl_s2_ff;
  dmb_pkg::dmb_word_t     bus_s1_ff;
  dmb_pkg::dmb_word_t     bus_s2_ff;
  logic                   clk_prev_ff;
  logic                   rise_ff;
  wire                    nxt_rise = ctl_s2_ff.port_clock & ~clk_prev_ff;

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      // idle means deselected, so no output enable flickers out of reset
      ctl_s1_ff   <= `DMB_CTL_IDLE;
      ctl_s2_ff   <= `DMB_CTL_IDLE;
      bus_s1_ff   <= `DMB_WORD_ZERO;
      bus_s2_ff   <= `DMB_WORD_ZERO;
      clk_prev_ff <= `DMB_BIT_RST;
      rise_ff     <= `DMB_BIT_RST;
    end else begin
      ctl_s1_ff   <= i_ctl;
      ctl_s2_ff   <= ctl_s1_ff;
      bus_s1_ff   <= i_bus;
      bus_s2_ff   <= bus_s1_ff;
      clk_prev_ff <= ctl_s2_ff.port_clock;
      rise_ff     <= nxt_rise;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // a third stage keeps the qualifiers aligned with the rise pulse
  dmb_pkg::dmb_port_ctl_t ctl_s3_ff;
  dmb_pkg::dmb_word_t     bus_s3_ff;

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      ctl_s3_ff <= `DMB_CTL_IDLE;
      bus_s3_ff <= `DMB_WORD_ZERO;
    end else begin
      ctl_s3_ff <= ctl_s2_ff;
      bus_s3_ff <= bus_s2_ff;
    end
  end

  assign o_rise = rise_ff;
  assign o_ctl  = ctl_s3_ff;
  assign o_bus  = bus_s3_ff;

endmodule

// ==== design/dmb_mailbox.sv ====
// dual port mailbox bypass: two letter registers with full flags
//
// Operation
// (R01) Two 36-bit letter registers, one per direction, are reached when a port's mail select is high.
// (R02) A qualified port-A write with mail select high loads the port-A bus into the A-to-B letter.
// (R03) A qualified port-B write with mail select high loads the port-B bus into the B-to-A letter.
// (R04) An accepted letter write drives that letter's active-low full flag low.
// (R05) While a full flag is low further writes to that letter are ignored and the data kept.
// (R06) Driven port-B outputs show the FIFO output word with mail select low, else the A-to-B letter.
// (R07) Driven port-A outputs always show the B-to-A letter.
// (R08) A qualified port-B read with mail select high returns the A-to-B full flag high.
// (R09) A qualified port-A read with mail select high returns the B-to-A full flag high.
// (R10) Reading a letter never changes it; only an accepted write does.
// (R11) A port-A transfer counts only on a port-A clock rise with select low and gate high.
// (R12) A port-B transfer counts only on a port-B clock rise with select low and gate high.
// (R13) Port A writes with direction high and reads low; port B writes low and reads high.
// (R14) Each writer waits for the far reader to release the full flag before sending new mail; the bench writes without waiting.
`include "dmb_defines.svh"

module dmb_mailbox (
  input  wire logic               i_sys_clk,
  input  wire logic               i_sys_rst,
  input  wire logic               i_port_a_clock,
  input  wire logic               i_port_a_select_n,
  input  wire logic               i_port_a_gate,
  input  wire logic               i_port_a_direction,
  input  wire logic               i_port_a_mail_select,
  input  wire dmb_pkg::dmb_word_t i_port_a_bus,
  output dmb_pkg::dmb_word_t      o_port_a_bus,
  output logic                    o_port_a_bus_oe,
  input  wire logic               i_port_b_clock,
  input  wire logic               i_port_b_select_n,
  input  wire logic               i_port_b_gate,
  input  wire logic               i_port_b_direction,
  input  wire logic               i_port_b_mail_select,
  input  wire dmb_pkg::dmb_word_t i_port_b_bus,
  output dmb_pkg::dmb_word_t      o_port_b_bus,
  output logic                    o_port_b_bus_oe,
  input  wire dmb_pkg::dmb_word_t i_fifo_out_word,
  output logic                    o_a_to_b_full_n,
  output logic                    o_b_to_a_full_n
);

  ////////////////////////////////////////////////////////////////////////////
  // pin sampling
  dmb_pkg::dmb_port_ctl_t a_pins;
  dmb_pkg::dmb_port_ctl_t b_pins;
  dmb_pkg::dmb_port_ctl_t a_ctl;
  dmb_pkg::dmb_port_ctl_t b_ctl;
  dmb_pkg::dmb_word_t     a_bus;
  dmb_pkg::dmb_word_t     b_bus;
  logic                   a_rise;
  logic                   b_rise;

  assign a_pins = '{port_clock:  i_port_a_clock,
                    select_n:    i_port_a_select_n,
                    gate:        i_port_a_gate,
                    direction:   i_port_a_direction,
                    mail_select: i_port_a_mail_select};
  assign b_pins = '{port_clock:  i_port_b_clock,
                    select_n:    i_port_b_select_n,
                    gate:        i_port_b_gate,
                    direction:   i_port_b_direction,
                    mail_select: i_port_b_mail_select};

  dmb_port_sync u_sync_a (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .i_ctl     (a_pins),
    .i_bus     (i_port_a_bus),
    .o_rise    (a_rise),
    .o_ctl     (a_ctl),
    .o_bus     (a_bus)
  );

  dmb_port_sync u_sync_b (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .i_ctl     (b_pins),
    .i_bus     (i_port_b_bus),
    .o_rise    (b_rise),
    .o_ctl     (b_ctl),
    .o_bus     (b_bus)
  );

  ////////////////////////////////////////////////////////////////////////////
  // transfer decode
  function automatic logic mail_xfer(input logic rise,
                                     input dmb_pkg::dmb_port_ctl_t ctl,
                                     input logic want_dir);
    mail_xfer = rise & ~ctl.select_n & ctl.gate & ctl.mail_select
                & (ctl.direction == want_dir);  // R11 R12
  endfunction

  wire a_mail_wr = mail_xfer(a_rise, a_ctl, `DMB_DIR_A_WRITE);   // R13
  wire a_mail_rd = mail_xfer(a_rise, a_ctl, ~`DMB_DIR_A_WRITE);  // R13
  wire b_mail_wr = mail_xfer(b_rise, b_ctl, `DMB_DIR_B_WRITE);   // R13
  wire b_mail_rd = mail_xfer(b_rise, b_ctl, ~`DMB_DIR_B_WRITE);  // R13

  ////////////////////////////////////////////////////////////////////////////
  // letter registers and full flags
  dmb_pkg::dmb_word_t a_to_b_letter_reg_ff;
  dmb_pkg::dmb_word_t b_to_a_letter_reg_ff;
  logic               a_to_b_full_n_ff;
  logic               b_to_a_full_n_ff;

  // a write is only taken while the flag is high; reads never touch data
  wire ab_load = a_mail_wr & a_to_b_full_n_ff;  // R02 R05
  wire ba_load = b_mail_wr & b_to_a_full_n_ff;  // R03 R05

  // the set wins if a load and a release meet in one cycle, so no mail is lost
  function automatic logic next_full_n(input logic load,
                                       input logic rd_done,
                                       input logic full_n);
    if (load) begin
      next_full_n = `DMB_FULL_N_MAIL;
    end else begin
      next_full_n = rd_done | full_n;
    end
  endfunction

  // a letter only moves on a load, so a read can never disturb it
  function automatic dmb_pkg::dmb_word_t next_letter(input logic               load,
                                                     input dmb_pkg::dmb_word_t word,
                                                     input dmb_pkg::dmb_word_t letter);
    next_letter = load ? word : letter;
  endfunction

  wire nxt_a_to_b_full_n = next_full_n(ab_load, b_mail_rd, a_to_b_full_n_ff);  // R04 R08
  wire nxt_b_to_a_full_n = next_full_n(ba_load, a_mail_rd, b_to_a_full_n_ff);  // R04 R09

  wire dmb_pkg::dmb_word_t nxt_ab_letter =
    next_letter(ab_load, a_bus, a_to_b_letter_reg_ff);  // R01 R10
  wire dmb_pkg::dmb_word_t nxt_ba_letter =
    next_letter(ba_load, b_bus, b_to_a_letter_reg_ff);  // R01 R10

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      a_to_b_letter_reg_ff <= `DMB_WORD_ZERO;
    end else begin
      a_to_b_letter_reg_ff <= nxt_ab_letter;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      b_to_a_letter_reg_ff <= `DMB_WORD_ZERO;
    end else begin
      b_to_a_letter_reg_ff <= nxt_ba_letter;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      a_to_b_full_n_ff <= `DMB_FULL_N_RST;
    end else begin
      a_to_b_full_n_ff <= nxt_a_to_b_full_n;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      b_to_a_full_n_ff <= `DMB_FULL_N_RST;
    end else begin
      b_to_a_full_n_ff <= nxt_b_to_a_full_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output drive; enables follow the synchronised qualifiers, so they lag the pins
  dmb_pkg::dmb_word_t port_a_bus_ff;
  dmb_pkg::dmb_word_t port_b_bus_ff;
  logic               port_a_bus_oe_ff;
  logic               port_b_bus_oe_ff;

  // a port drives only while selected and set to read; gate plays no part in drive
  function automatic logic drives_bus(input dmb_pkg::dmb_port_ctl_t ctl,
                                      input logic                   write_dir);
    drives_bus = ~ctl.select_n & (ctl.direction != write_dir);
  endfunction

  wire nxt_port_a_oe = drives_bus(a_ctl, `DMB_DIR_A_WRITE);
  wire nxt_port_b_oe = drives_bus(b_ctl, `DMB_DIR_B_WRITE);
  wire b_show_letter = b_ctl.mail_select;  // R06
  wire dmb_pkg::dmb_word_t nxt_port_a_bus = nxt_ba_letter;  // R07
  wire dmb_pkg::dmb_word_t nxt_port_b_bus =
    b_show_letter ? nxt_ab_letter : i_fifo_out_word;  // R06

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      port_a_bus_ff <= `DMB_WORD_ZERO;
    end else begin
      port_a_bus_ff <= nxt_port_a_bus;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      port_b_bus_ff <= `DMB_WORD_ZERO;
    end else begin
      port_b_bus_ff <= nxt_port_b_bus;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      port_a_bus_oe_ff <= `DMB_BIT_RST;
    end else begin
      port_a_bus_oe_ff <= nxt_port_a_oe;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      port_b_bus_oe_ff <= `DMB_BIT_RST;
    end else begin
      port_b_bus_oe_ff <= nxt_port_b_oe;
    end
  end

  assign o_port_a_bus    = port_a_bus_ff;
  assign o_port_b_bus    = port_b_bus_ff;
  assign o_port_a_bus_oe = port_a_bus_oe_ff;
  assign o_port_b_bus_oe = port_b_bus_oe_ff;
  assign o_a_to_b_full_n = a_to_b_full_n_ff;
  assign o_b_to_a_full_n = b_to_a_full_n_ff;

endmodule

// ==== design/dmb_mailbox_end.sv ====
// spare design file of the mailbox block; it holds no logic

// ==== verification/dmb_mailbox_sva.sv ====
// port-level assertions for the mailbox block
module dmb_mailbox_sva (
  input wire logic               i_sys_clk,
  input wire logic               i_sys_rst,
  input wire logic               i_port_a_select_n,
  input wire logic               i_port_a_gate,
  input wire logic               i_port_a_direction,
  input wire logic               i_port_a_mail_select,
  input wire logic               i_port_b_select_n,
  input wire logic               i_port_b_gate,
  input wire logic               i_port_b_direction,
  input wire logic               i_port_b_mail_select,
  input wire dmb_pkg::dmb_word_t i_fifo_out_word,
  input wire dmb_pkg::dmb_word_t o_port_a_bus,
  input wire logic               o_port_a_bus_oe,
  input wire dmb_pkg::dmb_word_t o_port_b_bus,
  input wire logic               o_port_b_bus_oe,
  input wire logic               o_a_to_b_full_n,
  input wire logic               o_b_to_a_full_n
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking dcb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  wire logic qa = !i_port_a_select_n && i_port_a_gate && i_port_a_mail_select;
  wire logic qb = !i_port_b_select_n && i_port_b_gate && i_port_b_mail_select;
  wire logic wa = qa && i_port_a_direction;
  wire logic ra = qa && !i_port_a_direction;
  wire logic wb = qb && !i_port_b_direction;
  wire logic rb = qb && i_port_b_direction;
  ////////////////////////////////////////////////////////////////////////////
  // qualifiers are held around the pin edge, so four cycles back is mid-window
  a_ab_set_cause: assert property ($fell(o_a_to_b_full_n) |-> $past(wa, 4))
    else $error("a-to-b flag fell without port A letter write");
  a_ab_clr_cause: assert property ($rose(o_a_to_b_full_n) |-> $past(rb, 4))
    else $error("a-to-b flag rose without port B letter read");
  a_ba_set_cause: assert property ($fell(o_b_to_a_full_n) |-> $past(wb, 4))
    else $error("b-to-a flag fell without port B letter write");
  a_ba_clr_cause: assert property ($rose(o_b_to_a_full_n) |-> $past(ra, 4))
    else $error("b-to-a flag rose without port A letter read");
  a_ba_full_hold: assert property (!$past(o_b_to_a_full_n) |-> $stable(o_port_a_bus))
    else $error("b-to-a letter changed while full");
  a_ba_write_only: assert property ($changed(o_port_a_bus) |-> $fell(o_b_to_a_full_n))
    else $error("port A bus changed without accepted write");
  a_oe_a_drive: assert property ((!i_port_a_select_n && !i_port_a_direction)[*6]
    |=> o_port_a_bus_oe)
    else $error("port A not driven during read select");
  a_oe_b_off: assert property (i_port_b_select_n[*6] |=> !o_port_b_bus_oe)
    else $error("port B driven while deselected");
  a_b_fifo_path: assert property ((!i_port_b_mail_select && $stable(i_fifo_out_word))[*6]
    |=> o_port_b_bus == $past(i_fifo_out_word))
    else $error("port B bus not fifo word");
  c_ab_set: cover property ($fell(o_a_to_b_full_n));
  c_ba_clr: cover property ($rose(o_b_to_a_full_n));
  c_refused: cover property (!o_a_to_b_full_n && wa);
endmodule

// ==== verification/dmb_port_party.sv ====
// behavioural processor on one port: pulses the port clock pin per transfer
module dmb_port_party (
  input  wire logic          i_sys_clk,
  output logic               o_clock,
  output logic               o_select_n,
  output logic               o_gate,
  output logic               o_direction,
  output logic               o_mail_select,
  output dmb_pkg::dmb_word_t o_bus
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {o_clock, o_select_n, o_gate, o_direction, o_mail_select, o_bus} = {4'h4, 37'h0};
  // port clock stands low between transfers; qualifiers stay put afterwards
  task automatic xfer(input logic [3:0] c, input dmb_pkg::dmb_word_t w, input int slow);
    @(posedge i_sys_clk) #1;
    {o_select_n, o_gate, o_direction, o_mail_select, o_bus} = {c, w};
    repeat (3 + slow) @(posedge i_sys_clk);
    #1 o_clock = 1'h1;
    repeat (3) @(posedge i_sys_clk);
    #1 o_clock = 1'h0;
    repeat (3) @(posedge i_sys_clk);
    #1 o_bus = ~w; // released bus must not look like the last word
  endtask
endmodule

// ==== verification/dmb_mailbox_test.sv ====
// self-checking bench for the dual port mailbox bypass
module dmb_mailbox_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_sys_clk = 1'h0, i_sys_rst = 1'h1, fab = 1'h1, fba = 1'h1;
  logic [3:0] ca = 4'h8, cb = 4'h8;
  dmb_pkg::dmb_word_t fifo_w = 36'h0, ab = 36'h0, ba = 36'h0, pa_w, pb_w, oa, ob;
  logic pa_c, pa_sn, pa_g, pa_d, pa_ms, pb_c, pb_sn, pb_g, pb_d, pb_ms;
  logic oa_oe, ob_oe, mf_ab, mf_ba;
  int n_mismatch = 0, n_tests = 0, cyc = 0;
  logic [4:0] dir_t [10] = '{5'h07, 5'h07, 5'h13, 5'h1f, 5'h16, 5'h17, 5'h15, 5'h15, 5'h06,
    5'h05};
  dmb_port_party u_pa (.i_sys_clk(i_sys_clk), .o_clock(pa_c), .o_select_n(pa_sn),
    .o_gate(pa_g), .o_direction(pa_d), .o_mail_select(pa_ms), .o_bus(pa_w));
  dmb_port_party u_pb (.i_sys_clk(i_sys_clk), .o_clock(pb_c), .o_select_n(pb_sn),
    .o_gate(pb_g), .o_direction(pb_d), .o_mail_select(pb_ms), .o_bus(pb_w));
  dmb_mailbox u_dut (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_port_a_clock(pa_c),
    .i_port_a_select_n(pa_sn), .i_port_a_gate(pa_g), .i_port_a_direction(pa_d),
    .i_port_a_mail_select(pa_ms), .i_port_a_bus(pa_w), .o_port_a_bus(oa),
    .o_port_a_bus_oe(oa_oe), .i_port_b_clock(pb_c), .i_port_b_select_n(pb_sn),
    .i_port_b_gate(pb_g), .i_port_b_direction(pb_d), .i_port_b_mail_select(pb_ms),
    .i_port_b_bus(pb_w), .o_port_b_bus(ob), .o_port_b_bus_oe(ob_oe),
    .i_fifo_out_word(fifo_w), .o_a_to_b_full_n(mf_ab), .o_b_to_a_full_n(mf_ba));
  always #10 i_sys_clk = ~i_sys_clk;
  task automatic print_verdict();
    $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 4000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  task automatic chk(input string nm, input dmb_pkg::dmb_word_t exp, got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic chk_bit(input string nm, input logic exp, got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // c is {select_n, gate, direction, mail_select}; the model updates after the pin pulse
  task automatic op(input logic b, input logic [3:0] c, input dmb_pkg::dmb_word_t w);
    logic acc;
    acc = !c[3] && c[2] && c[0];
    fifo_w = 36'({$urandom, $urandom});
    if (b) cb = c;
    else ca = c;
    if (b) u_pb.xfer(c, w, $urandom % 2);
    else u_pa.xfer(c, w, $urandom % 2);
    if (acc && !b && c[1] && fab) {ab, fab} = {w, 1'h0};
    if (acc && b && !c[1] && fba) {ba, fba} = {w, 1'h0};
    if (acc && b && c[1]) fab = 1'h1;
    if (acc && !b && !c[1]) fba = 1'h1;
    repeat (2) @(posedge i_sys_clk);
    #1 chk_bit("a_to_b_full_n", fab, mf_ab);
    chk_bit("b_to_a_full_n", fba, mf_ba);
    chk_bit("port_a_oe", !ca[3] && !ca[1], oa_oe);
    chk_bit("port_b_oe", !cb[3] && cb[1], ob_oe);
    if (!ca[3] && !ca[1]) chk("port_a_bus", ba, oa);
    if (!cb[3] && cb[1]) chk("port_b_bus", cb[0] ? ab : fifo_w, ob);
  endtask
  initial begin
    void'($urandom(54));
    repeat (4) @(posedge i_sys_clk);
    #1 i_sys_rst = 1'h0;
    // the read enables must stay off while the synchronisers refill after reset
    repeat (4) begin
      @(posedge i_sys_clk) #1;
      chk_bit("port_a_oe", 1'h0, oa_oe);
      chk_bit("port_b_oe", 1'h0, ob_oe);
    end
    // this table writes each letter twice before its release, so the second write is refused; the random run ignores release too
    foreach (dir_t[i]) op(dir_t[i][4], dir_t[i][3:0], 36'({$urandom, $urandom}));
    for (int i = 0; i < 40; i++) begin
      op(1'($urandom), {$urandom % 4 == 0, $urandom % 4 != 0, 1'($urandom),
        $urandom % 4 != 0}, 36'({$urandom, $urandom}));
    end
    print_verdict();
  end
endmodule
bind dmb_mailbox dmb_mailbox_sva u_sva (
  .i_sys_clk            (i_sys_clk),
  .i_sys_rst            (i_sys_rst),
  .i_port_a_select_n    (i_port_a_select_n),
  .i_port_a_gate        (i_port_a_gate),
  .i_port_a_direction   (i_port_a_direction),
  .i_port_a_mail_select (i_port_a_mail_select),
  .i_port_b_select_n    (i_port_b_select_n),
  .i_port_b_gate        (i_port_b_gate),
  .i_port_b_direction   (i_port_b_direction),
  .i_port_b_mail_select (i_port_b_mail_select),
  .i_fifo_out_word      (i_fifo_out_word),
  .o_port_a_bus         (o_port_a_bus),
  .o_port_a_bus_oe      (o_port_a_bus_oe),
  .o_port_b_bus         (o_port_b_bus),
  .o_port_b_bus_oe      (o_port_b_bus_oe),
  .o_a_to_b_full_n      (o_a_to_b_full_n),
  .o_b_to_a_full_n      (o_b_to_a_full_n)
);
